// ===== arsf_cand_rom.sv
// Candidate table: maps a serial rate index and reference selection to the
// serdes settings and output clock divider; output is registered.
// Assumes index 7 is the highest rate (6.144) and 0 the lowest (0.6144).
`timescale 1ns/1ps
module arsf_cand_rom (
    input  wire logic                 clock_i,  // System clock
    input  wire logic [2:0]           idx_i,    // Serial rate index
    input  wire logic [1:0]           ref_i,    // Reference selection
    output arsf_pkg::arsf_cand_t      cand_o    // Registered candidate
);

    logic [1:0] rate_mode;   // Rate mode of the index
    logic [4:0] mult;        // Pll multiplier value
    logic [3:0] mcode;       // Pll multiplier field code

    // Rate pairs share a mode; odd indices are the obsai family
    always_comb begin
        case (idx_i[2:1])
            2'h0:    rate_mode = arsf_pkg::RATE_EIGHTH;
            2'h1:    rate_mode = arsf_pkg::RATE_QUARTER;
            2'h2:    rate_mode = arsf_pkg::RATE_HALF;
            default: rate_mode = arsf_pkg::RATE_FULL;
        endcase
    end

    // Multiplier per family and reference clock
    always_comb begin
        case (ref_i)
            arsf_pkg::REF_122P88: mult = idx_i[0] ? arsf_pkg::MULT_O_122 : arsf_pkg::MULT_C_122;
            arsf_pkg::REF_307P2:  mult = idx_i[0] ? arsf_pkg::MULT_O_307 : arsf_pkg::MULT_C_307;
            default:              mult = idx_i[0] ? arsf_pkg::MULT_O_153 : arsf_pkg::MULT_C_153;
        endcase
    end

    // Compress multiplier into the 4-bit field
    always_comb begin
        case (mult)
            arsf_pkg::MULT_C_307: mcode = arsf_pkg::MCODE_8;
            arsf_pkg::MULT_O_307: mcode = arsf_pkg::MCODE_10;
            arsf_pkg::MULT_C_153: mcode = arsf_pkg::MCODE_16;
            arsf_pkg::MULT_O_153: mcode = arsf_pkg::MCODE_20;
            default:              mcode = arsf_pkg::MCODE_25;
        endcase
    end

    // Registered lookup; divider from vco/2 equals multiplier half way
    always_ff @(posedge clock_i) begin
        cand_o.serdes.tx_rate              <= rate_mode;
        cand_o.serdes.rx_rate              <= rate_mode;
        cand_o.serdes.pll_multiplier_field <= mcode;
        // Division 8/20/8 or 10/25/10 keeps output at 153.6 or 61.44 MHz
        cand_o.clk_div <= (ref_i == arsf_pkg::REF_153P6) ? (idx_i[0] ? 5'h0a : 5'h08)
                                                         : mult;
    end

endmodule

// ===== arsf_dwell_timer.sv
// Dwell timer: counts interval times 1024 reference periods, restarts on
// request and pulses expiry once per dwell.
// Assumes the reference clock is the module clock.
`timescale 1ns/1ps
module arsf_dwell_timer (
    input  wire logic        clock_i,    // Reference clock
    input  wire logic        rst_i,      // Synchronous reset
    input  wire logic        restart_i,  // Clear count
    input  wire logic [20:0] interval_i, // Dwell interval
    output logic             expire_o    // One-cycle expiry pulse
);

    logic [30:0] count_ff;   // Reference periods elapsed
    logic [30:0] limit;      // Periods in one dwell

    // Zero interval still dwells one unit, so the loop never stalls
    assign limit = (interval_i == 21'h000000) ? arsf_pkg::DWELL_UNIT
                 : {interval_i, {arsf_pkg::DWELL_UNIT_LOG2{1'b0}}};

    // Counter restarts on each candidate change expiry comes a cycle
    // early because the engine's restart spends the last cycle of the dwell
    always_ff @(posedge clock_i) begin
        if (rst_i || restart_i) begin
            count_ff <= 31'h00000000;
            expire_o <= 1'b0;
        end else if (count_ff >= limit - 31'h00000002) begin
            count_ff <= 31'h00000000;
            expire_o <= 1'b1;
        end else begin
            count_ff <= count_ff + 31'h00000001;
            expire_o <= 1'b0;
        end
    end

endmodule

// ===== arsf_link_partner.sv
// Far end transmitter model: sync rises once local settings match the line.
// Assumes the bench chooses the line settings and whether the link is up.
`timescale 1ns/1ps
module arsf_link_partner (
    input  wire logic                   clock_i,  // Local clock
    input  wire arsf_pkg::arsf_serdes_t serdes_i, // Settings under test
    input  wire arsf_pkg::arsf_serdes_t want_i,   // Settings fitting the line rate
    input  wire logic                   up_i,     // Transmitter active
    output logic                        sync_o,   // Channel sync level
    output logic                        cdr_o     // Cdr lock level
);
    logic [4:0] run_ff; // Cycles of matching settings
    // Sync needs a settled match, like a real comma hunt, never instant
    always_ff @(posedge clock_i) begin
        run_ff <= (up_i && serdes_i == want_i) ? run_ff + {4'h0, run_ff != 5'h1f} : 5'h00;
        sync_o <= run_ff > 5'h0f;
        cdr_o  <= up_i;
    end
endmodule

// ===== arsf_pkg.sv
// Package for the automatic rate sense controller: register offsets, fields,
// reset values, candidate table encodings and shared structs.
// Assumes a single 200 MHz clock domain; all files reference it by scope.
package arsf_pkg;

    // Register word offsets on the plain register port
    localparam logic [3:0] OFS_SERDES_CTRL = 4'h1;  // Rate tx/rx and pll multiplier
    localparam logic [3:0] OFS_STATUS      = 4'h5;  // Lock flag and candidate index
    localparam logic [3:0] OFS_SENSE_CTRL  = 4'ha;  // Sense enable, signal loss select
    localparam logic [3:0] OFS_CAND_CFG    = 4'hb;  // Ref select, mask, dwell high bits
    localparam logic [3:0] OFS_DWELL_LO    = 4'hc;  // Dwell interval low bits
    localparam logic [3:0] OFS_IRQ_STATUS  = 4'hd;  // Sticky event bits, read only
    localparam logic [3:0] OFS_IRQ_CLEAR   = 4'he;  // Write one to clear
    localparam logic [3:0] OFS_IRQ_ENABLE  = 4'hf;  // Interrupt enables

    // Field positions
    localparam int TX_RATE_LSB   = 6;
    localparam int RX_RATE_LSB   = 4;
    localparam int PLL_MULTIPLIER_FIELD_LSB  = 0;
    localparam int LOCK_BIT      = 10;
    localparam int SENSE_EN_LSB  = 12;
    localparam int LOS_SEL_BIT   = 0;
    localparam int REF_SEL_LSB   = 14;
    localparam int MASK_LSB      = 6;
    localparam int DWELL_HI_LSB  = 0;

    // Reset values
    localparam logic [15:0] SERDES_CTRL_RST = 16'h0000;
    localparam logic [1:0]  SENSE_EN_RST    = 2'h0;
    localparam logic [1:0]  REF_SEL_RST     = 2'h0;
    localparam logic [7:0]  MASK_RST        = 8'hff;
    localparam logic [20:0] DWELL_RST       = 21'h000100;
    localparam logic [2:0]  IRQ_EN_RST      = 3'h0;

    // Dwell granularity: reference periods per interval unit
    localparam int          DWELL_UNIT_LOG2 = 10;
    localparam logic [30:0] DWELL_UNIT      = 31'h00000400;

    // Rate-select pin code handing control to software
    localparam logic [2:0] PIN_SW_CODE = 3'h4;

    // Reference clock selections
    localparam logic [1:0] REF_153P6  = 2'h0;
    localparam logic [1:0] REF_122P88 = 2'h1;
    localparam logic [1:0] REF_307P2  = 2'h2;

    // Rate mode encodings: full, half, quarter, eighth
    localparam logic [1:0] RATE_FULL    = 2'h0;
    localparam logic [1:0] RATE_HALF    = 2'h1;
    localparam logic [1:0] RATE_QUARTER = 2'h2;
    localparam logic [1:0] RATE_EIGHTH  = 2'h3;

    // Pll multipliers for the cpri and obsai families
    localparam logic [4:0] MULT_C_153 = 5'h10;  // 16
    localparam logic [4:0] MULT_C_122 = 5'h14;  // 20
    localparam logic [4:0] MULT_C_307 = 5'h08;  // 8
    localparam logic [4:0] MULT_O_153 = 5'h14;  // 20
    localparam logic [4:0] MULT_O_122 = 5'h19;  // 25
    localparam logic [4:0] MULT_O_307 = 5'h0a;  // 10

    // Pll multiplier field codes (4-bit field cannot hold 16..25 directly)
    localparam logic [3:0] MCODE_8  = 4'h0;
    localparam logic [3:0] MCODE_10 = 4'h1;
    localparam logic [3:0] MCODE_16 = 4'h2;
    localparam logic [3:0] MCODE_20 = 4'h3;
    localparam logic [3:0] MCODE_25 = 4'h4;

    // Interrupt event bits
    localparam int EV_LOCK   = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_WRAP   = 2;

    // Sense state machine, gray along search -> locked -> retry
    typedef enum logic [1:0] {
        ARSF_IDLE   = 2'b00,
        ARSF_SEARCH = 2'b01,
        ARSF_LOCKED = 2'b11,
        ARSF_RETRY  = 2'b10
    } arsf_state_t;

    // Settings driven to the serdes
    typedef struct packed {
        logic [1:0] tx_rate;
        logic [1:0] rx_rate;
        logic [3:0] pll_multiplier_field;
    } arsf_serdes_t;

    // One candidate, with its output clock divider
    typedef struct packed {
        arsf_serdes_t serdes;
        logic [4:0]   clk_div;
    } arsf_cand_t;

endpackage

// ===== arsf_rate_sense.sv
// Automatic rate sense controller for one channel: loops candidate settings,
// reports lock, overrides serdes fields, drives clock divider and interrupt.
// Assumes sync_i and cdr_lock_i are pin level signals from another domain.
`timescale 1ns/1ps
module arsf_rate_sense (
    input  wire logic                  clock_i,          // 200 MHz clock
    input  wire logic                  rst_i,            // Synchronous reset
    input  wire logic [3:0]            reg_addr_i,       // Register word address
    input  wire logic [15:0]           reg_wdata_i,      // Write data
    input  wire logic                  reg_wr_i,         // Write strobe
    input  wire logic                  reg_rd_i,         // Read strobe
    output logic [15:0]                reg_rdata_o,      // Read data, next cycle
    input  wire logic [2:0]            rate_pins_i,      // Rate-select pins
    input  wire logic                  sync_i,           // Channel sync from pin domain
    input  wire logic                  cdr_lock_i,       // Cdr lock from pin domain
    output arsf_pkg::arsf_serdes_t     serdes_o,         // Settings to serdes
    output logic [4:0]                 clk_div_o,        // Output clock divider
    output logic                       signal_loss_output_o, // Loss output
    output logic                       irq_o             // Level interrupt
);

    // Register fields
    arsf_pkg::arsf_serdes_t manual_ff;        // Software serdes fields
    logic [1:0]             sense_en_ff;      // Software enable field
    logic                   los_sel_ff;       // Route lock onto loss output
    logic                   raw_los_ff;       // Registered raw loss level
    logic [1:0]             ref_sel_ff;       // Reference selection
    logic [7:0]             mask_ff;          // Candidate rate mask
    logic [20:0]            dwell_ff;         // Dwell interval
    logic [2:0]             irq_stat_ff;      // Sticky events
    logic [2:0]             irq_en_ff;        // Event enables

    // Sense engine
    arsf_pkg::arsf_state_t  state_ff;         // Engine state
    arsf_pkg::arsf_state_t  nxt_state;        // Next engine state
    logic [2:0]             idx_ff;           // Current candidate index
    logic [2:0]             nxt_idx;          // Next candidate index
    logic                   lock_ff;          // Rate lock flag
    logic [2:0]             sync_meta_ff;     // Sync synchroniser stages
    logic [1:0]             cdr_meta_ff;      // Cdr synchroniser stages
    logic [5:0]             pins_meta_ff;     // Rate pin synchroniser stages
    logic                   sync_q;           // Qualified sync
    logic                   restart;          // Dwell restart request
    logic                   expire;           // Dwell expired
    logic [2:0]             irq_set;          // Event pulses this cycle
    logic                   enabled;          // Sense enabled
    logic                   en_d_ff;          // Enable last cycle
    logic [2:0]             lower_idx;        // Next lower enabled rate
    logic                   has_lower;        // One lower is enabled
    logic [2:0]             top_idx;          // Highest enabled rate
    arsf_pkg::arsf_cand_t   cand;             // Looked-up candidate
    arsf_pkg::arsf_serdes_t applied;          // Settings actually driven

    // Pin code 100 hands control to software; other codes enable from pins
    assign enabled = (pins_meta_ff[5:3] == arsf_pkg::PIN_SW_CODE) ? (sense_en_ff != 2'h0) : pins_meta_ff[5];

    // Pin synchronisers; a first stage feeds only its next stage
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync_meta_ff <= 3'h0;
            cdr_meta_ff  <= 2'h0;
            pins_meta_ff <= 6'h00;
        end else begin
            sync_meta_ff <= {sync_meta_ff[1:0], sync_i};
            cdr_meta_ff  <= {cdr_meta_ff[0], cdr_lock_i};
            pins_meta_ff <= {pins_meta_ff[2:0], rate_pins_i};
        end
    end

    // Cdr lock qualifies channel synchronization
    assign sync_q = sync_meta_ff[2] && cdr_meta_ff[1];

    // Highest enabled and next lower enabled index from the mask
    always_comb begin
        top_idx   = 3'h7;
        lower_idx = idx_ff;
        has_lower = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (mask_ff[i]) begin
                top_idx = 3'(i);
            end
            if (mask_ff[i] && (3'(i) < idx_ff)) begin
                lower_idx = 3'(i);
                has_lower = 1'b1;
            end
        end
    end

    // Engine next state
    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        restart   = 1'b0;
        irq_set   = 3'h0;
        case (state_ff)
            arsf_pkg::ARSF_IDLE: begin
                if (enabled) begin
                    nxt_state = arsf_pkg::ARSF_SEARCH;
                    nxt_idx   = top_idx;
                    restart   = 1'b1;
                end
            end
            arsf_pkg::ARSF_SEARCH,
            arsf_pkg::ARSF_RETRY: begin
                if (sync_q) begin
                    nxt_state = arsf_pkg::ARSF_LOCKED;
                    irq_set[arsf_pkg::EV_LOCK] = 1'b1;
                end else if (expire) begin
                    nxt_state = arsf_pkg::ARSF_SEARCH;
                    restart   = 1'b1;
                    if (has_lower) begin
                        nxt_idx = lower_idx;
                    end else begin
                        nxt_idx = top_idx;
                        irq_set[arsf_pkg::EV_WRAP] = 1'b1;
                    end
                end
            end
            arsf_pkg::ARSF_LOCKED: begin
                if (!sync_q) begin
                    nxt_state = arsf_pkg::ARSF_RETRY;
                    restart   = 1'b1;                   // Same index, one dwell
                    irq_set[arsf_pkg::EV_UNLOCK] = 1'b1;
                end
            end
            default: begin
                nxt_state = arsf_pkg::ARSF_IDLE;
            end
        endcase
        if (!enabled) begin
            nxt_state = arsf_pkg::ARSF_IDLE;
        end
        if (enabled && !en_d_ff) begin
            restart = 1'b1;
        end
    end

    // Engine registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_ff <= arsf_pkg::ARSF_IDLE;
            idx_ff   <= 3'h7;
            en_d_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
            en_d_ff  <= enabled;
        end
    end

    // Lock flag follows sync; drops on the same edge that enters retry
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lock_ff <= 1'b0;
        end else begin
            lock_ff <= (nxt_state == arsf_pkg::ARSF_LOCKED);
        end
    end

    // Candidate lookup by index and reference selection
    arsf_cand_rom u_rom (
        .clock_i (clock_i),
        .idx_i   (idx_ff),
        .ref_i   (ref_sel_ff),
        .cand_o  (cand)
    );

    // Dwell timer of interval times 1024
    arsf_dwell_timer u_dwell (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .restart_i  (restart),
        .interval_i (dwell_ff),
        .expire_o   (expire)
    );

    // Engine settings win while enabled
    assign applied = enabled ? cand.serdes : manual_ff;

    // Serdes outputs; divider parks at 8 outside sense mode, where it is unused
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            serdes_o  <= arsf_pkg::SERDES_CTRL_RST[7:0];
            clk_div_o <= 5'h08;
        end else begin
            serdes_o  <= applied;
            clk_div_o <= enabled ? cand.clk_div : 5'h08;
        end
    end

    // Loss output optionally shows inverted lock
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            raw_los_ff           <= 1'b1;
            signal_loss_output_o <= 1'b1;
        end else begin
            raw_los_ff           <= !cdr_meta_ff[1];
            signal_loss_output_o <= los_sel_ff ? !lock_ff : raw_los_ff;
        end
    end

    // Register writes; serdes fields always store but do not drive when enabled
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            manual_ff   <= arsf_pkg::SERDES_CTRL_RST[7:0];
            sense_en_ff <= arsf_pkg::SENSE_EN_RST;
            los_sel_ff  <= 1'b0;
            ref_sel_ff  <= arsf_pkg::REF_SEL_RST;
            mask_ff     <= arsf_pkg::MASK_RST;
            dwell_ff    <= arsf_pkg::DWELL_RST;
            irq_en_ff   <= arsf_pkg::IRQ_EN_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                arsf_pkg::OFS_SERDES_CTRL: manual_ff <= reg_wdata_i[7:0];
                arsf_pkg::OFS_SENSE_CTRL: begin
                    sense_en_ff <= reg_wdata_i[arsf_pkg::SENSE_EN_LSB +: 2];
                    los_sel_ff  <= reg_wdata_i[arsf_pkg::LOS_SEL_BIT];
                end
                arsf_pkg::OFS_CAND_CFG: begin
                    ref_sel_ff      <= reg_wdata_i[arsf_pkg::REF_SEL_LSB +: 2];
                    mask_ff         <= reg_wdata_i[arsf_pkg::MASK_LSB +: 8];
                    dwell_ff[20:16] <= reg_wdata_i[arsf_pkg::DWELL_HI_LSB +: 5];
                end
                arsf_pkg::OFS_DWELL_LO:   dwell_ff[15:0] <= reg_wdata_i;
                arsf_pkg::OFS_IRQ_ENABLE: irq_en_ff <= reg_wdata_i[2:0];
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
    end

    // Sticky events; a set in the clear cycle wins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_stat_ff <= 3'h0;
        end else if (reg_wr_i && (reg_addr_i == arsf_pkg::OFS_IRQ_CLEAR)) begin
            irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[2:0]) | irq_set;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
        end
    end

    // Level interrupt from registered enabled status
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // Read data one cycle after the strobe; zero otherwise and for unmapped
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                // Reads show the driven settings while enabled
                arsf_pkg::OFS_SERDES_CTRL: reg_rdata_o <= {8'h00, (enabled ? cand.serdes : manual_ff)};
                arsf_pkg::OFS_STATUS:      reg_rdata_o <= {5'h00, lock_ff, 7'h00, idx_ff};
                arsf_pkg::OFS_SENSE_CTRL:  reg_rdata_o <= {2'h0, sense_en_ff, 11'h000, los_sel_ff};
                arsf_pkg::OFS_CAND_CFG:    reg_rdata_o <= {ref_sel_ff, mask_ff, 1'b0, dwell_ff[20:16]};
                arsf_pkg::OFS_DWELL_LO:    reg_rdata_o <= dwell_ff[15:0];
                arsf_pkg::OFS_IRQ_STATUS:  reg_rdata_o <= {13'h0000, irq_stat_ff};
                arsf_pkg::OFS_IRQ_ENABLE:  reg_rdata_o <= {13'h0000, irq_en_ff};
                default:                   reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

endmodule

// ===== arsf_rate_sense_chk.sv
// Port checker for the rate sense block.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
module arsf_rate_sense_chk (
    input wire logic                   clock_i,
    input wire logic                   rst_i,
    input wire logic [3:0]             reg_addr_i,
    input wire logic                   reg_rd_i,
    input wire logic [15:0]            reg_rdata_o,
    input wire arsf_pkg::arsf_serdes_t serdes_o,
    input wire logic [4:0]             clk_div_o,
    input wire logic                   signal_loss_output_o,
    input wire logic                   irq_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_rst; $fell(rst_i) |-> reg_rdata_o == 16'h0 && serdes_o == 8'h0
        && clk_div_o == 5'h08 && signal_loss_output_o && !irq_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs wrong after reset");
    property p_gap; !$past(reg_rd_i) |-> reg_rdata_o == 16'h0; endproperty
    a_gap: assert property (p_gap) else $error("read data outside its cycle");
    property p_unm; reg_rd_i && reg_addr_i inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9}
        |=> reg_rdata_o == 16'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    // Dwell is far longer than eight cycles, so settings never flicker
    property p_hold; $changed(serdes_o) |-> ##3 $stable(serdes_o) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("settings changed too soon");
    property p_txrx; serdes_o.tx_rate == serdes_o.rx_rate; endproperty
    a_txrx: assert property (p_txrx) else $error("tx and rx rate differ");
    property p_mult; serdes_o.pll_multiplier_field <= 4'h4; endproperty
    a_mult: assert property (p_mult) else $error("multiplier code out of range");
    property p_div; clk_div_o inside {5'h08, 5'h0a, 5'h14, 5'h19}; endproperty
    a_div: assert property (p_div) else $error("divider not a table value");
    property p_d25; clk_div_o == 5'h19 |-> serdes_o.pll_multiplier_field == 4'h4; endproperty
    a_d25: assert property (p_d25) else $error("divider 25 without multiplier 25");
    property p_d20; clk_div_o == 5'h14 |-> serdes_o.pll_multiplier_field == 4'h3; endproperty
    a_d20: assert property (p_d20) else $error("divider 20 without multiplier 20");
endmodule
bind arsf_rate_sense arsf_rate_sense_chk u_chk (.clock_i, .rst_i, .reg_addr_i, .reg_rd_i,
    .reg_rdata_o, .serdes_o, .clk_div_o, .signal_loss_output_o, .irq_o);

// ===== testbench.sv
// Bench: register port tasks, a link model and an index model of the search.
// Assumes dwell interval 1, so each candidate lasts 1024 cycles.
`timescale 1ns/1ps
module testbench;
    logic                   clock_i, rst_i, reg_wr_i, reg_rd_i, sync_i, cdr_lock_i, up, loss, irq;
    logic [3:0]             reg_addr_i;
    logic [15:0]            reg_wdata_i, rdata, v;
    logic [2:0]             rate_pins_i;
    logic [4:0]             div;
    logic [7:0]             mask;
    logic [12:0]            e;
    arsf_pkg::arsf_serdes_t ser, want;
    integer                 n_mismatch, num_checks, seed, k, s, r, cur, t;
    integer                 cyc = 0;
    arsf_rate_sense DUT (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o(rdata), .rate_pins_i, .sync_i, .cdr_lock_i, .serdes_o(ser), .clk_div_o(div),
        .signal_loss_output_o(loss), .irq_o(irq));
    arsf_link_partner u_far (.clock_i, .serdes_i(ser), .want_i(want), .up_i(up), .sync_o(sync_i),
        .cdr_o(cdr_lock_i));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // Hang guard, well above the 32k cycles the run needs
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Step past an edge and let its updates land before touching anything
    task automatic tick(input integer n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // A gap cycle after each strobe keeps every signal to one change a step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        tick(1);
        reg_wr_i    <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        tick(1);
        d = rdata;
        reg_rd_i   <= 1'b0;
        tick(1);
    endtask
    // Model settings {tx, rx, multiplier code, divider} of rate index i, reference rf
    function automatic logic [12:0] exp_set(input integer i, input integer rf);
        logic [1:0] rt;
        logic [3:0] m;
        logic [4:0] d;
        rt = 2'(3 - i / 2);
        m = (rf == 1) ? 4'(3 + i % 2) : (rf == 2) ? 4'(i % 2) : 4'(2 + i % 2);
        d = (rf == 1) ? 5'(20 + 5 * (i % 2)) : 5'(8 + 2 * (i % 2));
        return {rt, rt, m, d};
    endfunction
    // Next lower enabled index, wrapping to the highest
    function automatic integer nxt(input integer i, input logic [7:0] m);
        for (int j = 1; j <= 8; j++) begin
            if (m[(i + 8 - j) % 8])
                return (i + 8 - j) % 8;
        end
        return i;
    endfunction
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, up} = 4'h8;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        rate_pins_i = 3'h4;
        want = 8'h00;
        seed = 4;
        n_mismatch = 0;
        num_checks = 0;
        tick(3);
        rst_i <= 1'b0;
        chk("reset outputs", {2'h0, loss, ser, div}, {2'h0, 1'b1, 8'h00, 5'h08});
        rd(arsf_pkg::OFS_STATUS, v);
        chk("reset status", v, 16'h0007);
        rd(4'h3, v);
        chk("unmapped", v, 16'h0000);
        // Each reference in turn, a mid-run reset before each, random rate mask
        for (k = 0; k < 3; k++) begin
            r = (k + 1) % 3;
            rst_i <= 1'b1;
            tick(2);
            rst_i <= 1'b0;
            mask = 8'($random(seed)) | 8'h01;
            wr(arsf_pkg::OFS_CAND_CFG, {2'(r), mask, 6'h00});
            wr(arsf_pkg::OFS_DWELL_LO, 16'h0001);
            wr(arsf_pkg::OFS_SENSE_CTRL, 16'h1001);
            cur = nxt(0, mask);
            tick(512);
            for (s = 0; s < 9; s++) begin
                rd(arsf_pkg::OFS_STATUS, v);
                chk("index", v, 16'(cur));
                chk("settings", {3'h0, ser, div}, {3'h0, exp_set(cur, r)});
                cur = nxt(cur, mask);
                tick(1022);
            end
        end
        // Line runs at the next candidate; lock must come within its dwell
        t = nxt(cur, mask);
        e = exp_set(t, 0);
        want <= e[12:5];
        up <= 1'b1;
        wr(arsf_pkg::OFS_IRQ_ENABLE, 16'h0001);
        tick(1022);
        rd(arsf_pkg::OFS_STATUS, v);
        chk("locked", v, 16'h0400 | 16'(t));
        chk("irq and loss", {14'h0, irq, loss}, 16'h0002);
        wr(arsf_pkg::OFS_SERDES_CTRL, 16'h0051);
        rd(arsf_pkg::OFS_SERDES_CTRL, v);
        chk("applied", {3'h0, v[7:0], div}, {3'h0, e});
        chk("driven", {8'h0, ser}, {8'h0, e[12:5]});
        wr(arsf_pkg::OFS_IRQ_CLEAR, 16'h0007);
        tick(2);
        chk("irq cleared", {15'h0, irq}, 16'h0000);
        // Link drops: one retry of the same setting, then the next lower
        up <= 1'b0;
        tick(512);
        rd(arsf_pkg::OFS_STATUS, v);
        chk("retry", v, 16'(t));
        chk("loss on drop", {15'h0, loss}, 16'h0001);
        tick(1022);
        rd(arsf_pkg::OFS_STATUS, v);
        chk("after retry", v, 16'(nxt(t, mask)));
        wr(arsf_pkg::OFS_SENSE_CTRL, 16'h0000);
        tick(8);
        chk("manual", {8'h0, ser}, 16'h0051);
        // Pin code 101 enables with the field cleared
        rate_pins_i <= 3'h5;
        tick(6);
        e = exp_set(nxt(0, mask), 0);
        chk("pin enable", {3'h0, ser, div}, {3'h0, e});
        wrap_up;
    end
endmodule
